// ### shared/bhc_pkg.sv
/*
  constants and carrier types of the beam height classifier.
  assumes one scan of all beams per scan_done pulse.
*/

package bhc_pkg;

  localparam int unsigned BHC_BEAMS = 32;
  localparam int unsigned BHC_RLC_HALF = BHC_BEAMS / 2;
  localparam int unsigned BHC_RLC_CLAMP = (BHC_RLC_HALF < 16) ? 16 :
                                          ((BHC_RLC_HALF > 120) ? 120 : BHC_RLC_HALF);
  localparam logic [7:0] BHC_RLC_MAX = 8'(BHC_RLC_CLAMP);
  localparam logic [7:0] BHC_BEAM_CNT = 8'(BHC_BEAMS);

  // cycles the device stays unreachable after a factory reset
  localparam logic [7:0] BHC_FACTORY_HOLD = 8'h10;

  // register byte offsets
  localparam logic [7:0] BHC_OFS_CTRL = 8'h00;
  localparam logic [7:0] BHC_OFS_FACTORY = 8'h04;
  localparam logic [7:0] BHC_OFS_CFG0 = 8'h08;
  localparam logic [7:0] BHC_OFS_CFG1 = 8'h0c;
  localparam logic [7:0] BHC_OFS_STATUS = 8'h10;
  localparam logic [7:0] BHC_OFS_EDGES = 8'h14;
  localparam logic [7:0] BHC_OFS_COUNTS = 8'h18;
  localparam logic [7:0] BHC_OFS_BEAMS = 8'h1c;
  localparam logic [7:0] BHC_OFS_TAUGHT = 8'h20;

  // control register bits
  localparam int unsigned BHC_CTRL_REVERSE = 0;
  localparam int unsigned BHC_CTRL_LOCK = 1;
  localparam int unsigned BHC_CTRL_PD_EN = 2;
  localparam int unsigned BHC_CTRL_TEACH_GO = 3;
  localparam int unsigned BHC_CTRL_TEACH_PAT = 4;

  // configuration register fields
  localparam int unsigned BHC_CFG_FROM_LAST = 3;
  localparam int unsigned BHC_CFG_REF_LSB = 8;

  // status register bits
  localparam int unsigned BHC_ST_TAUGHT = 0;
  localparam int unsigned BHC_ST_BUSY = 1;
  localparam int unsigned BHC_ST_FAIL = 2;
  localparam int unsigned BHC_ST_ALIGN = 3;
  localparam int unsigned BHC_ST_SW_LSB = 4;

  typedef enum logic [2:0] {
    BHC_FN_OFF = 3'b000,
    BHC_FN_GE = 3'b001,
    BHC_FN_LE = 3'b010,
    BHC_FN_EQ = 3'b011,
    BHC_FN_AUTO_MAX = 3'b100,
    BHC_FN_PATTERN = 3'b101
  } bhc_func_type;

  typedef enum logic [1:0] {
    BHC_TEACH_IDLE = 2'b00,
    BHC_TEACH_HEIGHT = 2'b01,
    BHC_TEACH_PATTERN = 2'b10
  } bhc_teach_type;

  typedef struct packed {
    bhc_func_type func;
    logic from_last;
    logic [7:0] ref_beam;
  } bhc_cfg_type;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] last;
    logic [7:0] count;
    logic any;
  } bhc_stat_type;

endpackage

// ### verilog/bhc_beam_scan.sv
/*
  first, last and count of set bits of a beam vector, indices from one.
  assumes bit 0 is beam one in the chosen numbering.
*/
`timescale 1ns/1ps
`default_nettype none

module bhc_beam_scan
  import bhc_pkg::*;
(
  input wire logic [BHC_BEAMS-1:0] vec_i,
  output bhc_stat_type stat_o
);

  // scan from beam one upward
  always_comb begin
    stat_o = '0;
    for (int i = 0; i < BHC_BEAMS; i++) begin
      if (vec_i[i]) begin
        if (!stat_o.any) begin
          stat_o.first = 8'(i + 1);
        end
        stat_o.last = 8'(i + 1);
        stat_o.count = stat_o.count + 8'h01;
        stat_o.any = 1'b1;
      end
    end
  end

endmodule // bhc_beam_scan

`default_nettype wire

// ### verilog/bhc_classifier.sv
/*
  beam height classifier: numbering, teach-in, height and pattern
  functions on two switching outputs, wishbone classic register slave.
  assumes beams_i is stable when scan_done_i pulses, 1 = blocked.
*/
// Added by the designer: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

module bhc_classifier
  import bhc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [BHC_BEAMS-1:0] beams_i,
  input wire logic scan_done_i,
  input wire logic teach_btn_i,
  output logic [1:0] switch_o,
  output logic align_aid_o,
  output logic factory_busy_o
);

  typedef struct packed {
    logic reverse;
    logic lock;
    logic pd_en;
    logic teach_pat;
    bhc_cfg_type cfg0;
    bhc_cfg_type cfg1;
    bhc_teach_type teach;
    logic taught;
    logic fail;
    logic align;
    logic dir_last;
    logic [7:0] taught_h;
    logic [BHC_BEAMS-1:0] pattern;
    logic [1:0] sw;
    bhc_stat_type blk_snap;
    bhc_stat_type mad_snap;
    logic [7:0] rlc_snap;
    logic [BHC_BEAMS-1:0] beam_snap;
    logic btn_prev;
    logic [7:0] hold;
    logic ack;
    logic [31:0] rdata;
  } bhc_state_type;

  bhc_state_type s_reg;
  bhc_state_type s_next;

  logic [BHC_BEAMS-1:0] ord;
  logic [BHC_BEAMS-1:0] made;
  bhc_stat_type blk;
  bhc_stat_type mad;
  logic [7:0] run_length_transitions;
  logic [7:0] cog_lo;
  logic [7:0] cog_hi;
  logic [7:0] h_first;
  logic [7:0] h_last;
  logic auto_last;
  logic [31:0] wmask;
  logic [31:0] ctrl_word;
  logic [31:0] cfg0_word;
  logic [31:0] cfg1_word;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_cfg0;
  logic [31:0] wr_cfg1;
  logic bus_req;
  logic wr_en;
  logic teach_go;

  // defaults after reset and after a factory reset
  function automatic bhc_state_type bhc_defaults();
    bhc_state_type d;
    d = '0;
    d.teach = BHC_TEACH_IDLE;
    d.cfg0.func = BHC_FN_OFF;
    d.cfg1.func = BHC_FN_OFF;
    d.align = 1'b1;
    return d;
  endfunction

  // unpack a configuration word
  function automatic bhc_cfg_type bhc_cfg_of(logic [31:0] w);
    bhc_cfg_type c;
    c.func = bhc_func_type'(w[2:0]);
    c.from_last = w[BHC_CFG_FROM_LAST];
    c.ref_beam = w[BHC_CFG_REF_LSB +: 8];
    return c;
  endfunction

  // pack a configuration for readback
  function automatic logic [31:0] bhc_cfg_word(bhc_cfg_type c);
    logic [31:0] w;
    w = '0;
    w[2:0] = c.func;
    w[BHC_CFG_FROM_LAST] = c.from_last;
    w[BHC_CFG_REF_LSB +: 8] = c.ref_beam;
    return w;
  endfunction

  // criterion of one output for the current scan
  function automatic logic bhc_eval(bhc_cfg_type c, logic any, logic [7:0] hf,
                                    logic [7:0] hl, logic [7:0] th, logic tl,
                                    logic pat_hit);
    logic [7:0] h;
    logic r;
    h = c.from_last ? hl : hf;
    r = 1'b0;
    case (c.func)
      BHC_FN_GE: begin
        r = any && (c.ref_beam != 8'h00) && (h >= c.ref_beam);
      end
      BHC_FN_LE: begin
        r = any && (h <= c.ref_beam);
      end
      BHC_FN_EQ: begin
        r = any && (h == c.ref_beam);
      end
      BHC_FN_AUTO_MAX: begin
        r = any && ((tl ? hl : hf) > th);
      end
      BHC_FN_PATTERN: begin
        r = pat_hit;
      end
      default: begin
        r = 1'b0;
      end
    endcase
    return r;
  endfunction

  always_comb begin
    for (int i = 0; i < BHC_BEAMS; i++) begin
      ord[i] = s_reg.reverse ? beams_i[BHC_BEAMS-1-i] : beams_i[i];
    end
    made = ~ord;
  end

  // edge beams and counts on the ordered vector
  bhc_beam_scan u_blk (
    .vec_i(ord),
    .stat_o(blk)
  );

  bhc_beam_scan u_mad (
    .vec_i(made),
    .stat_o(mad)
  );

  // transitions and blocked balance of both halves
  always_comb begin
    run_length_transitions = 8'h00;
    cog_lo = 8'h00;
    cog_hi = 8'h00;
    for (int i = 0; i < BHC_BEAMS - 1; i++) begin
      if (ord[i] != ord[i+1]) begin
        run_length_transitions = run_length_transitions + 8'h01;
      end
    end
    for (int i = 0; i < BHC_BEAMS; i++) begin
      if (ord[i] && (i < BHC_BEAMS / 2)) begin
        cog_lo = cog_lo + 8'h01;
      end
      if (ord[i] && (i >= BHC_BEAMS / 2)) begin
        cog_hi = cog_hi + 8'h01;
      end
    end
  end

  // heights seen from either end
  always_comb begin
    h_first = blk.last;
    h_last = blk.any ? (BHC_BEAM_CNT + 8'h01 - blk.first) : 8'h00;
    if (ord[0] && !ord[BHC_BEAMS-1]) begin
      auto_last = 1'b0;
    end else if (ord[BHC_BEAMS-1] && !ord[0]) begin
      auto_last = 1'b1;
    end else begin
      auto_last = !(cog_lo > cog_hi);
    end
  end

  // bus decode and byte-lane merge
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{wb_sel_i[b]}};
    end
    ctrl_word = '0;
    ctrl_word[BHC_CTRL_REVERSE] = s_reg.reverse;
    ctrl_word[BHC_CTRL_LOCK] = s_reg.lock;
    ctrl_word[BHC_CTRL_PD_EN] = s_reg.pd_en;
    ctrl_word[BHC_CTRL_TEACH_PAT] = s_reg.teach_pat;
    cfg0_word = bhc_cfg_word(s_reg.cfg0);
    cfg1_word = bhc_cfg_word(s_reg.cfg1);
    wr_ctrl = (ctrl_word & ~wmask) | (wb_dat_i & wmask);
    wr_cfg0 = (cfg0_word & ~wmask) | (wb_dat_i & wmask);
    wr_cfg1 = (cfg1_word & ~wmask) | (wb_dat_i & wmask);
    // no answer while the device restarts
    bus_req = wb_cyc_i && wb_stb_i && !s_reg.ack && (s_reg.hold == 8'h00);
    wr_en = bus_req && wb_we_i;
  end

  // next state
  always_comb begin
    s_next = s_reg;
    s_next.ack = bus_req;
    s_next.btn_prev = teach_btn_i;
    teach_go = 1'b0;

    // read data, process data hidden while disabled
    if (bus_req) begin
      s_next.rdata = '0;
      case (wb_adr_i)
        BHC_OFS_CTRL: s_next.rdata = ctrl_word;
        BHC_OFS_CFG0: s_next.rdata = cfg0_word;
        BHC_OFS_CFG1: s_next.rdata = cfg1_word;
        BHC_OFS_STATUS: begin
          s_next.rdata[BHC_ST_TAUGHT] = s_reg.taught;
          s_next.rdata[BHC_ST_BUSY] = (s_reg.teach != BHC_TEACH_IDLE);
          s_next.rdata[BHC_ST_FAIL] = s_reg.fail;
          s_next.rdata[BHC_ST_ALIGN] = s_reg.align;
          s_next.rdata[BHC_ST_SW_LSB +: 2] = s_reg.sw;
        end
        BHC_OFS_EDGES: begin
          if (s_reg.pd_en) begin
            s_next.rdata = {s_reg.mad_snap.last, s_reg.mad_snap.first,
                            s_reg.blk_snap.last, s_reg.blk_snap.first};
          end
        end
        BHC_OFS_COUNTS: begin
          if (s_reg.pd_en) begin
            s_next.rdata = {8'h00, s_reg.rlc_snap, s_reg.mad_snap.count,
                            s_reg.blk_snap.count};
          end
        end
        BHC_OFS_BEAMS: begin
          if (s_reg.pd_en) begin
            s_next.rdata = 32'(s_reg.beam_snap);
          end
        end
        BHC_OFS_TAUGHT: begin
          s_next.rdata = {23'h000000, s_reg.dir_last, s_reg.taught_h};
        end
        default: s_next.rdata = '0;
      endcase
    end

    // register writes
    if (wr_en) begin
      case (wb_adr_i)
        BHC_OFS_CTRL: begin
          s_next.reverse = wr_ctrl[BHC_CTRL_REVERSE];
          s_next.lock = wr_ctrl[BHC_CTRL_LOCK];
          s_next.pd_en = wr_ctrl[BHC_CTRL_PD_EN];
          s_next.teach_pat = wr_ctrl[BHC_CTRL_TEACH_PAT];
          teach_go = wr_ctrl[BHC_CTRL_TEACH_GO] && wb_sel_i[0];
        end
        BHC_OFS_CFG0: s_next.cfg0 = bhc_cfg_of(wr_cfg0);
        BHC_OFS_CFG1: s_next.cfg1 = bhc_cfg_of(wr_cfg1);
        default: begin
        end
      endcase
    end

    if (teach_btn_i && !s_reg.btn_prev && !s_reg.lock) begin
      teach_go = 1'b1;
    end

    // teach request waits for the next scan end
    if (teach_go && (s_reg.teach == BHC_TEACH_IDLE)) begin
      if (wr_en && (wb_adr_i == BHC_OFS_CTRL)) begin
        s_next.teach = wr_ctrl[BHC_CTRL_TEACH_PAT] ? BHC_TEACH_PATTERN
                                                    : BHC_TEACH_HEIGHT;
      end else begin
        s_next.teach = s_reg.teach_pat ? BHC_TEACH_PATTERN : BHC_TEACH_HEIGHT;
      end
    end

    // evaluate and latch once per scan
    if (scan_done_i) begin
      s_next.blk_snap = blk;
      s_next.mad_snap = mad;
      s_next.rlc_snap = run_length_transitions;
      s_next.beam_snap = ord;
      s_next.sw[0] = s_reg.taught && bhc_eval(s_reg.cfg0, blk.any, h_first, h_last,
                                              s_reg.taught_h, s_reg.dir_last,
                                              ord == s_reg.pattern);
      s_next.sw[1] = s_reg.taught && bhc_eval(s_reg.cfg1, blk.any, h_first, h_last,
                                              s_reg.taught_h, s_reg.dir_last,
                                              ord == s_reg.pattern);
      case (s_reg.teach)
        BHC_TEACH_IDLE: begin
        end
        BHC_TEACH_HEIGHT: begin
          s_next.teach = BHC_TEACH_IDLE;
          s_next.fail = !blk.any;
          if (blk.any) begin
            s_next.taught = 1'b1;
            s_next.align = 1'b0;
            s_next.dir_last = auto_last;
            s_next.taught_h = auto_last ? h_last : h_first;
          end
        end
        BHC_TEACH_PATTERN: begin
          s_next.teach = BHC_TEACH_IDLE;
          s_next.fail = (run_length_transitions > BHC_RLC_MAX);
          if (run_length_transitions <= BHC_RLC_MAX) begin
            s_next.taught = 1'b1;
            s_next.align = 1'b0;
            s_next.pattern = ord;
          end
        end
        default: s_next.teach = BHC_TEACH_IDLE;
      endcase
    end

    // factory reset: defaults, then unreachable for a while
    if (wr_en && (wb_adr_i == BHC_OFS_FACTORY) && wb_sel_i[0] &&
        (wb_dat_i[7:0] == 8'h01)) begin
      s_next = bhc_defaults();
      s_next.ack = 1'b1;
      s_next.hold = BHC_FACTORY_HOLD;
    end else if (s_reg.hold != 8'h00) begin
      s_next = bhc_defaults();
      s_next.hold = s_reg.hold - 8'h01;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_reg <= bhc_defaults();
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from state
  assign wb_ack_o = s_reg.ack;
  assign wb_dat_o = s_reg.rdata;
  assign switch_o = s_reg.sw;
  assign align_aid_o = s_reg.align;
  assign factory_busy_o = (s_reg.hold != 8'h00);

endmodule // bhc_classifier

`default_nettype wire

// ### verification/bhc_assertions.sv
/*
  port timing checks of the beam height classifier.
  assumes it is bound to bhc_classifier.
*/
`timescale 1ns/1ps
`default_nettype none
module bhc_assertions
  import bhc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic scan_done_i,
  input wire logic [1:0] switch_o,
  input wire logic align_aid_o,
  input wire logic factory_busy_o
);
  logic [7:0] hold_reg;
  logic [7:0] hold_next;
  // length of the running factory hold
  always_comb hold_next = factory_busy_o ? hold_reg + 8'h01 : 8'h00;
  always_ff @(posedge clk_i) begin
    hold_reg <= rst_i ? 8'h00 : hold_next;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_OUT: assert property ($fell(rst_i) |-> align_aid_o && switch_o == 2'b00)
    else $error("outputs not idle after reset");
  AST_SW_SCAN: assert property ($changed(switch_o) |->
    $past(scan_done_i) || factory_busy_o || $past(factory_busy_o) || $past(rst_i))
    else $error("switch moved outside a scan end");
  AST_UNTAUGHT: assert property (align_aid_o && $past(align_aid_o) |-> switch_o == 2'b00)
    else $error("switch active while untaught");
  AST_HOLD_LEN: assert property ($fell(factory_busy_o) && !$past(rst_i) |->
    hold_reg == BHC_FACTORY_HOLD)
    else $error("factory hold length wrong");
  AST_HOLD_MAX: assert property (hold_reg <= BHC_FACTORY_HOLD)
    else $error("factory hold too long");
  AST_FACT_DEF: assert property ($fell(factory_busy_o) |-> align_aid_o && switch_o == 2'b00)
    else $error("defaults missing after factory reset");
  AST_HOLD_NOACK: assert property (factory_busy_o && $past(factory_busy_o) |-> !wb_ack_o)
    else $error("ack during factory hold");
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !factory_busy_o
    |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_UNMAPPED: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h23 |->
    wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
endmodule // bhc_assertions
bind bhc_classifier bhc_assertions chk_u (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .scan_done_i, .switch_o, .align_aid_o, .factory_busy_o);
`default_nettype wire

// ### verification/bhc_optics_model.sv
/*
  optics stand-in: shows a beam vector and ends each scan with a pulse.
  assumes one scan request at a time, go_i high for one cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module bhc_optics_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] dly_i,
  input wire logic [31:0] obj_i,
  output logic [31:0] beams_o,
  output logic scan_done_o
);
  logic [1:0] wait_reg;
  logic run_reg;
  // idle lines at time zero
  initial begin
    beams_o = 32'h0;
    scan_done_o = 1'b0;
    run_reg = 1'b0;
  end
  always @(posedge clk_i) begin
    scan_done_o <= 1'b0;
    if (go_i) begin
      run_reg <= 1'b1;
      wait_reg <= dly_i;
      beams_o <= obj_i;
    end else if (run_reg && wait_reg == 2'h0) begin
      run_reg <= 1'b0;
      scan_done_o <= 1'b1;
    end else if (run_reg) begin
      wait_reg <= wait_reg - 2'h1;
    end else begin
      beams_o <= ~beams_o; // lines not held between scans
    end
  end
endmodule // bhc_optics_model
`default_nettype wire

// ### verification/bhc_classifier_tb.sv
/*
  self-checking bench of the beam height classifier.
  assumes the optics model and the bound checker are compiled with it.
*/
`timescale 1ns/1ps
`default_nettype none
module bhc_classifier_tb;
  logic clk_i = 1'b0;
  logic rst_i, req, we, btn, go, scan_done, scan_d, ack, align, fbusy;
  logic [7:0] adr;
  logic [1:0] dly, sw;
  logic [31:0] wdat, rdat, obj, m, cf;
  logic [bhc_pkg::BHC_BEAMS-1:0] beams;
  logic [31:0] exp_q[$];
  string nm_q[$];
  integer seed;
  int errors = 0;
  int compares = 0;
  int h, r, n;
  logic [31:0] t_obj[4] = '{32'hffc00000, 32'h00000038, 32'h83f00001, 32'h000003ff};
  logic [31:0] t_exp[4] = '{32'h10a, 32'h006, 32'h120, 32'h00a};
  // free running clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  bhc_classifier dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .beams_i(beams), .scan_done_i(scan_done), .teach_btn_i(btn),
    .switch_o(sw), .align_aid_o(align), .factory_busy_o(fbusy));
  bhc_optics_model optics_u (.clk_i(clk_i), .go_i(go), .dly_i(dly), .obj_i(obj),
    .beams_o(beams), .scan_done_o(scan_done));
  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic end_of_test;
    if (errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic give_up;
    errors++;
    end_of_test();
  endtask
  // one classic cycle, held until ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 40);
    req <= 1'b0;
    if (k >= 40) give_up();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    exp_q.push_back(e);
    nm_q.push_back(nm);
    bus(1'b0, a, 32'h0);
  endtask
  // one scan, switches expected after it
  task automatic scan(input logic [31:0] o, input logic [1:0] e, input string nm);
    int k;
    exp_q.push_back({30'h0, e});
    nm_q.push_back(nm);
    @(posedge clk_i);
    obj <= o;
    dly <= 2'($random(seed));
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (scan_done !== 1'b1 && k < 20);
    @(posedge clk_i);
    if (k >= 20) give_up();
  endtask
  task automatic press;
    @(posedge clk_i);
    btn <= 1'b1;
    repeat (2) @(posedge clk_i);
    btn <= 1'b0;
  endtask
  // pairs each answer with the oldest expectation
  always @(posedge clk_i) begin
    if ((ack && !we) || scan_d) begin
      if (exp_q.size() == 0) begin
        check("spare answer", 32'h1, 32'h0);
      end else begin
        check(nm_q.pop_front(), scan_d ? {30'h0, sw} : rdat, exp_q.pop_front());
      end
    end
    scan_d <= scan_done;
  end
  initial begin
    seed = 32'ha703274f;
    {rst_i, req, we, btn, go, scan_d} = 6'h20;
    adr = 8'h00;
    dly = 2'h0;
    wdat = 32'h0;
    obj = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h10, 32'h8, "status");
    rd(8'h40, 32'h0, "unmapped");
    bus(1'b1, 8'h08, 32'h101);
    scan(32'hff, 2'b00, "untaught");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 8'h00, 32'hc);
      scan(t_obj[i], (i == 0) ? 2'b00 : 2'b01, "ge one");
      rd(8'h20, t_exp[i], "taught");
    end
    check("align", {31'h0, align}, 32'h0);
    rd(8'h10, 32'h11, "status");
    bus(1'b1, 8'h08, 32'h4);
    scan(32'h7ff, 2'b01, "taller");
    scan(32'h3ff, 2'b00, "same");
    // random heights, both numberings and both reference ends
    for (int rv = 0; rv < 2; rv++) begin
      bus(1'b1, 8'h00, 32'h4 | 32'(rv));
      for (int k = 0; k < 8; k++) begin
        h = $unsigned($random(seed)) % 33;
        r = (k < 2 && h != 0) ? h : 1 + $unsigned($random(seed)) % 32;
        m = (h == 0) ? 32'h0 : 32'hffffffff >> (32 - h);
        if (k[1]) m = {<<{m}};
        if (rv != 0) m = {<<{m}};
        cf = {16'h0, 8'(r), 4'h0, k[1], 3'h0};
        bus(1'b1, 8'h08, cf | 32'h1);
        bus(1'b1, 8'h0c, cf | (k[0] ? 32'h3 : 32'h2));
        scan(m, {h != 0 && (k[0] ? h == r : h <= r), h >= r}, "height");
      end
    end
    bus(1'b1, 8'h08, 32'h0);
    bus(1'b1, 8'h0c, 32'h0);
    scan(32'hf8000000, 2'b00, "off");
    rd(8'h14, 32'h20060501, "edges");
    rd(8'h18, 32'h00011b05, "counts");
    rd(8'h1c, 32'h0000001f, "beams");
    bus(1'b1, 8'h00, 32'h1c);
    scan(32'hfffeaaaa, 2'b00, "off");
    rd(8'h10, 32'h5, "status");
    bus(1'b1, 8'h00, 32'h1c);
    scan(32'h0000aaaa, 2'b00, "off");
    bus(1'b1, 8'h08, 32'h5);
    scan(32'h0000aaaa, 2'b01, "pattern");
    scan(32'h0000aaab, 2'b00, "pattern");
    bus(1'b1, 8'h00, 32'h6);
    press();
    scan(32'h7, 2'b00, "locked");
    rd(8'h20, 32'h00a, "taught");
    bus(1'b1, 8'h00, 32'h4);
    press();
    scan(32'h7, 2'b00, "released");
    rd(8'h20, 32'h003, "taught");
    bus(1'b1, 8'h04, 32'h1);
    n = 0;
    while (fbusy !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (fbusy === 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    check("hold", 32'(n), 32'(bhc_pkg::BHC_FACTORY_HOLD));
    check("align", {31'h0, align}, 32'h1);
    rd(8'h10, 32'h8, "status");
    rd(8'h14, 32'h0, "edges");
    rd(8'h08, 32'h0, "cfg");
    bus(1'b1, 8'h08, 32'h101);
    scan(32'h3ff, 2'b00, "untaught");
    end_of_test();
  end
endmodule // bhc_classifier_tb
`default_nettype wire
